// File: hw/seconds_clock_map.svh
// register offsets, field positions, reset values and timing figures of the seconds clock
`ifndef SECONDS_CLOCK_MAP_SVH
`define SECONDS_CLOCK_MAP_SVH

`define UP_COUNT_OFS      8'h00
`define DOWN_COUNT_OFS    8'h04
`define MATCH0_OFS        8'h08
`define MATCH1_OFS        8'h0c
`define CONTROL_OFS       8'h10
`define EVENT_STATUS_OFS  8'h14
`define UNLOCK_KEY_OFS    8'h18
`define RETAIN_RAM_OFS    8'h80

`define CTRL_IRQ_EN0_BIT  0
`define CTRL_IRQ_EN1_BIT  1
`define CTRL_BLOCK_RST_BIT 4
`define CTRL_POWER_ON_REQUEST_OUTPUT_OFF_BIT 5
`define CTRL_STOP_BIT     6
`define CTRL_SW_POWER_ON_REQUEST_OUTPUT_BIT  7

`define STAT_MATCH0_BIT   0
`define STAT_MATCH1_BIT   1
`define STAT_POWER_ON_REQUEST_OUTPUT_BIT     2

`define UP_COUNT_RST      32'h0000_0000
`define DOWN_COUNT_RST    32'hffff_ffff
`define MATCH_RST         32'h0000_0000
`define CONTROL_RST       8'h00
`define STATUS_RST        3'h0
`define KEY_RST           32'h0000_0000
`define CTRL_POR_MASK     8'hf0

`define OSC_HZ            32768
`define TICK_HZ           1

`endif

// File: hw/seconds_clock_pkg.sv
// types shared by the seconds clock and whoever drives its register port
package seconds_clock_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

   typedef struct packed {
      logic [31:0] up_count;
      logic [31:0] down_count;
      logic [1:0][31:0] match;
      logic [7:0] control;
      logic [2:0] status;
      logic [31:0] key;
      logic [14:0] divider;
      logic [1:0] match_active;
      logic power_on;
      logic [31:0] rdata;
      logic [31:0][31:0] ram;
   } state_t;

endpackage

// File: hw/seconds_clock.sv
// battery-domain seconds clock: up/down counters, two matches, power-on request, retention ram
//
// Functional notes
// RULE1: 1 Hz tick from oscillator advances both counters
// RULE2: up counts elapsed, down starts all ones
// RULE3: software checks counters sum to fffffffe
// RULE4: control bit 4 high holds block reset
// RULE5: software stops counters before writing them
// RULE6: match when up counter equals match register
// RULE7: match interrupt needs enable, enables reset off
// RULE8: power-on request gated by unlock key
// RULE9: power-on request only while match active
// RULE10: enabled match drives request, control can disable
// RULE11: match power-on latched, cleared by writing 1
// RULE12: control bit 7 drives request when unlocked
// RULE13: no false request pulses during power-up
// RULE14: power-up reset clears only control bits 7:4; with a wrong key the code resets all control, counters, matches, status
// RULE15: defaults only through the block reset bit; power-up reset with a wrong key also loads them
// RULE16: thirty-two word retention ram, whole words only
// RULE17: software keeps inverted checksum in ram
// RULE18: match compared only at the 1 Hz tick
// RULE19: writing differing match value clears match
// RULE20: software waits one slow period before readback
// RULE21: writes and reads synchronised to the clock
//
// Our own choices: the plain strobed port and the address map.
`include "seconds_clock_map.svh"

module seconds_clock #(
   parameter int osc_hz = `OSC_HZ,
   parameter int tick_hz = `TICK_HZ,
   parameter logic [31:0] key_pattern = 32'h5a5a_c3c3
) (
   input wire logic clock,                                 // 20 MHz system clock
   input wire logic rst_b,                                 // chip power-up reset, active low
   input wire logic osc_tick,                              // one-cycle pulse per slow oscillator period
   input wire seconds_clock_pkg::bus_req_t bus_req,        // register port request
   output logic [31:0] rdata,                              // read data, cycle after the read strobe
   output logic match_irq,                                 // enabled match interrupt, level
   output logic power_on_request_output,                   // request toward the external supply
   output logic second_tick                                // one-cycle pulse per counted second
);

   // one full second of oscillator pulses; key value above is arbitrary
   localparam int div_top = osc_hz / tick_hz - 1;
   localparam logic [14:0] div_top_w = 15'(div_top);

   initial begin
      if (osc_hz < 2 || tick_hz < 1 || div_top > 32767 || (osc_hz % tick_hz) != 0) begin
         $error("seconds_clock: oscillator rate cannot be divided to the tick rate");
      end
   end

   seconds_clock_pkg::state_t s_q;
   seconds_clock_pkg::state_t s_d;

   logic key_ok;
   logic run;
   logic tick;
   logic [31:0] up_next;
   logic [1:0] hit;
   logic match_drive;
   logic in_ram;
   logic [4:0] ram_idx;
   logic [31:0] read_word;

   assign key_ok = (s_q.key == key_pattern);
   assign run = ~s_q.control[`CTRL_STOP_BIT];
   assign up_next = s_q.up_count + 32'h0000_0001;
   assign in_ram = bus_req.addr[7];
   assign ram_idx = bus_req.addr[6:2];

   // read mux; unmapped offsets answer zero
   always_comb begin
      read_word = 32'h0000_0000;
      if (in_ram) begin
         read_word = s_q.ram[ram_idx];
      end else begin
         unique case (bus_req.addr)
            `UP_COUNT_OFS: read_word = s_q.up_count;
            `DOWN_COUNT_OFS: read_word = s_q.down_count;
            `MATCH0_OFS: read_word = s_q.match[0];
            `MATCH1_OFS: read_word = s_q.match[1];
            `CONTROL_OFS: read_word = {24'h00_0000, s_q.control};
            `EVENT_STATUS_OFS: read_word = {29'h0000_0000, s_q.status};
            `UNLOCK_KEY_OFS: read_word = s_q.key;
            default: read_word = 32'h0000_0000;
         endcase
      end
   end

   always_comb begin
      s_d = s_q;
      tick = 1'b0;
      hit = 2'b00;
      match_drive = 1'b0;

      // RULE1: divide oscillator to 1 Hz
      if (osc_tick) begin
         if (s_q.divider >= div_top_w) begin
            s_d.divider = 15'h0000;
            tick = 1'b1;
         end else begin
            s_d.divider = s_q.divider + 15'h0001;
         end
      end

      // RULE1: advance counters per tick
      // RULE2: up and down together
      if (tick && run) begin
         s_d.up_count = up_next;
         s_d.down_count = s_q.down_count - 32'h0000_0001;
         for (int i = 0; i < 2; i++) begin
            // RULE18: compare only at tick
            // RULE6: equality of counter and match
            hit[i] = (up_next == s_q.match[i]);
            s_d.match_active[i] = hit[i];
         end
      end

      // RULE21: all writes taken in this clock
      if (bus_req.wr) begin
         if (in_ram) begin
            // RULE16: whole-word retention ram
            s_d.ram[ram_idx] = bus_req.wdata;
         end else begin
            unique case (bus_req.addr)
               `UP_COUNT_OFS: s_d.up_count = bus_req.wdata;
               `DOWN_COUNT_OFS: s_d.down_count = bus_req.wdata;
               `MATCH0_OFS: begin
                  s_d.match[0] = bus_req.wdata;
                  // RULE19: differing value drops match
                  if (bus_req.wdata != s_q.up_count) begin
                     s_d.match_active[0] = 1'b0;
                  end
               end
               `MATCH1_OFS: begin
                  s_d.match[1] = bus_req.wdata;
                  // RULE19: differing value drops match
                  if (bus_req.wdata != s_q.up_count) begin
                     s_d.match_active[1] = 1'b0;
                  end
               end
               `CONTROL_OFS: s_d.control = bus_req.wdata[7:0];
               // RULE11: write one clears status
               `EVENT_STATUS_OFS: s_d.status = s_q.status & ~bus_req.wdata[2:0];
               `UNLOCK_KEY_OFS: s_d.key = bus_req.wdata;
               default: s_d.key = s_d.key;
            endcase
         end
      end

      // sets come after clears so a coincident event is kept
      for (int i = 0; i < 2; i++) begin
         if (hit[i]) begin
            s_d.status[i] = 1'b1;
         end
      end

      // RULE10: match drives request unless disabled
      // RULE9: only while match is active
      match_drive = (|s_d.match_active) && !s_d.control[`CTRL_POWER_ON_REQUEST_OUTPUT_OFF_BIT];

      // RULE8: key gates the request
      // RULE12: software request when unlocked
      s_d.power_on = (s_d.key == key_pattern)
                     && (match_drive || s_d.control[`CTRL_SW_POWER_ON_REQUEST_OUTPUT_BIT]);

      // RULE11: latch match-caused request
      if (match_drive && (s_d.key == key_pattern)) begin
         s_d.status[`STAT_POWER_ON_REQUEST_OUTPUT_BIT] = 1'b1;
      end

      // RULE4: block reset held while bit is high
      // RULE15: path to register defaults, besides power-up with a wrong key
      if (s_q.control[`CTRL_BLOCK_RST_BIT]) begin
         s_d.up_count = `UP_COUNT_RST;
         s_d.down_count = `DOWN_COUNT_RST;
         s_d.match[0] = `MATCH_RST;
         s_d.match[1] = `MATCH_RST;
         s_d.status = `STATUS_RST;
         s_d.key = `KEY_RST;
         s_d.divider = 15'h0000;
         s_d.match_active = 2'b00;
         s_d.control[3:0] = 4'(`CONTROL_RST);
         s_d.power_on = 1'b0;
      end

      // RULE21: registered read answer, one cycle only
      s_d.rdata = bus_req.rd ? read_word : 32'h0000_0000;

      // RULE14: power-up reset clears control 7:4, all of control if key is wrong
      // RULE13: request held low through power-up
      if (!rst_b) begin
         s_d.control = s_q.control & ~`CTRL_POR_MASK;
         s_d.power_on = 1'b0;
         s_d.rdata = 32'h0000_0000;
         // a wrong key means the retained contents cannot be trusted
         if (!key_ok) begin
            s_d.up_count = `UP_COUNT_RST;
            s_d.down_count = `DOWN_COUNT_RST;
            s_d.match[0] = `MATCH_RST;
            s_d.match[1] = `MATCH_RST;
            s_d.control = `CONTROL_RST;
            s_d.status = `STATUS_RST;
            s_d.divider = 15'h0000;
            s_d.match_active = 2'b00;
         end
      end
   end

   always_ff @(posedge clock) begin
      s_q <= s_d;
   end

   assign rdata = s_q.rdata;
   assign power_on_request_output = s_q.power_on;

   // RULE7: interrupt needs its enable
   assign match_irq = (s_q.status[`STAT_MATCH0_BIT] && s_q.control[`CTRL_IRQ_EN0_BIT])
                      || (s_q.status[`STAT_MATCH1_BIT] && s_q.control[`CTRL_IRQ_EN1_BIT]);

   // tick is combinational from the divider flop and the oscillator pulse
   assign second_tick = tick && run;

endmodule

// File: verification/seconds_clock_checker.sv
// port assertions for the seconds clock
module seconds_clock_checker (
   input wire logic clock, // clock
   input wire logic rst_b, // reset
   input wire logic osc_tick, // slow pulse
   input wire seconds_clock_pkg::bus_req_t bus_req, // bus
   input wire logic [31:0] rdata, // read data
   input wire logic match_irq, // irq
   input wire logic power_on_request_output, // request
   input wire logic second_tick // second
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   sequence ram_write_read;
      bus_req.wr && bus_req.addr[7] ##2 bus_req.rd && bus_req.addr == $past(bus_req.addr, 2);
   endsequence
   rdata_idle_a: assert property (!$past(bus_req.rd) |-> rdata == 32'h0)
      else $error("rdata not idle");
   ram_echo_a: assert property (ram_write_read |=> rdata == $past(bus_req.wdata, 3))
      else $error("ram word lost");
   reset_quiet_a: assert property ($rose(rst_b) |-> !power_on_request_output && rdata == 32'h0)
      else $error("output after reset");
   tick_source_a: assert property (second_tick |-> osc_tick)
      else $error("tick without osc");
   tick_single_a: assert property (second_tick |=> !second_tick)
      else $error("tick too long");
   irq_rise_a: assert property ($rose(match_irq) |-> $past(second_tick) || $past(bus_req.wr))
      else $error("irq rose uncaused");
   irq_fall_a: assert property ($fell(match_irq) |-> $past(bus_req.wr))
      else $error("irq fell uncaused");
   request_cause_a: assert property ($changed(power_on_request_output) |->
      $past(second_tick) || $past(second_tick, 2) || $past(bus_req.wr) || $past(bus_req.wr, 2) ||
      !$past(rst_b, 2) || !$past(rst_b, 3))
      else $error("request moved uncaused");
endmodule

// File: verification/supply_model.sv
// external supply that powers up on each rising edge of the request
module supply_model (
   input wire logic clock, // clock
   input wire logic request, // power-on request
   output int n_on // power-ups seen
);
   timeunit 1ns;
   timeprecision 1ns;
   logic req_q = 1'b0;
   initial n_on = 0;
   always @(posedge clock) begin
      if (request === 1'b1 && req_q === 1'b0) n_on <= n_on + 1;
      req_q <= request;
   end
endmodule

// File: verification/tb_top.sv
// bench for the seconds clock
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] key_ok = 32'h1234_abcd; // arbitrary unlock value
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic osc_tick = 1'b0;
   seconds_clock_pkg::bus_req_t req = '0;
   logic [31:0] rdata, u, w;
   logic irq, pout, tick;
   logic [4:0] idx;
   int n_errors = 0;
   int compares = 0;
   int cyc = 0;
   int n_on, t0;
   seconds_clock #(.osc_hz(4), .key_pattern(key_ok)) dut_u (.clock(clock), .rst_b(rst_b), .osc_tick(osc_tick),
      .bus_req(req), .rdata(rdata), .match_irq(irq), .power_on_request_output(pout), .second_tick(tick));
   supply_model sup_u (.clock(clock), .request(pout), .n_on(n_on));
   always #25 clock = ~clock;
   // four cycles per slow pulse keeps a second at 16 cycles
   always @(posedge clock) begin
      cyc <= cyc + 1;
      osc_tick <= cyc % 4 == 3;
      if (cyc == 3000) begin
         n_errors++;
         test_done();
      end
   end
   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge clock);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      req.wr <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] exp, string name);
      @(posedge clock);
      req <= '{addr: a, wdata: $urandom, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      req.rd <= 1'b0;
      #1 chk(name, exp, rdata);
   endtask
   task automatic wait_tick();
      int i;
      i = 0;
      do begin
         @(posedge clock);
         #1 i++;
      end while (tick !== 1'b1 && i < 100);
      chk("tick wait", 32'h0, {31'h0, i >= 100});
   endtask
   task automatic settle();
      repeat (2) @(posedge clock);
      #1;
   endtask
   function automatic logic [31:0] down_of(logic [31:0] up);
      return 32'hffff_fffe - up;
   endfunction
   task automatic test_done();
      $display("n_errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      void'($urandom(32'hbb82));
      repeat (20) @(posedge clock);
      rst_b <= 1'b1;
      wr(8'h10, 32'h10);
      wr(8'h10, 32'h0);
      rd(8'h04, 32'hffff_ffff, "down");
      rd(8'h10, 32'h0, "control");
      rd(8'h14, 32'h0, "status");
      u = $urandom;
      wr(8'h10, 32'h40);
      wr(8'h00, u);
      wr(8'h04, down_of(u));
      wr(8'h18, key_ok);
      wr(8'h08, u + 32'h2);
      wr(8'h0c, u + 32'h2);
      rd(8'h04, down_of(u), "down");
      wr(8'h10, 32'h1);
      wait_tick();
      t0 = cyc;
      wait_tick();
      chk("tick gap", 32'd16, cyc - t0);
      wr(8'h10, 32'h41);
      settle();
      chk("request", 32'h1, {31'h0, pout});
      chk("irq", 32'h1, {31'h0, irq});
      rd(8'h00, u + 32'h2, "up");
      rd(8'h04, down_of(u) - 32'h2, "down");
      wr(8'h08, u + 32'h5);
      wr(8'h0c, u + 32'h5);
      settle();
      chk("request", 32'h0, {31'h0, pout});
      rd(8'h14, 32'h7, "status");
      wr(8'h14, 32'h5);
      rd(8'h14, 32'h2, "status");
      chk("irq", 32'h0, {31'h0, irq});
      wr(8'h10, 32'hc0);
      settle();
      chk("request", 32'h1, {31'h0, pout});
      wr(8'h18, 32'h0);
      settle();
      chk("request", 32'h0, {31'h0, pout});
      chk("power-ups", 32'h2, n_on);
      wr(8'h18, key_ok);
      wr(8'h10, 32'h43);
      rst_b <= 1'b0;
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      rd(8'h10, 32'h3, "control");
      rd(8'h08, u + 32'h5, "match0");
      for (int i = 0; i < 4; i++) begin
         idx = (i == 0) ? 5'd31 : 5'($urandom);
         w = $urandom;
         wr({1'b1, idx, 2'b00}, w);
         rd({1'b1, idx, 2'b00}, w, "ram");
      end
      wr(8'h80, ~w);
      rd(8'h80, ~w, "checksum");
      rd(8'h20, 32'h0, "unmapped");
      test_done();
   end
endmodule
bind seconds_clock seconds_clock_checker chk_u (.clock(clock), .rst_b(rst_b), .osc_tick(osc_tick), .bus_req(bus_req),
   .rdata(rdata), .match_irq(match_irq), .power_on_request_output(power_on_request_output), .second_tick(second_tick));
